// *** dtd_pkg.sv ***
`default_nettype none
package dtd_pkg;
  // ---------------------------------------------------------------
  // Register bus geometry
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 9;
  localparam int          DATA_W        = 8;
  localparam int          SAMPLE_W      = 16;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [8:0]  OFS_SEQ_CTRL  = 9'h14b;
  localparam logic [8:0]  OFS_REAL_ERR  = 9'h14c;
  localparam logic [8:0]  OFS_IMAG_ERR  = 9'h14d;
  localparam logic [8:0]  OFS_CONST_HI  = 9'h14e;
  localparam logic [8:0]  OFS_CONST_LO  = 9'h14f;
  localparam logic [8:0]  OFS_DIGITAL_TEST_SELECT  = 9'h150;
  localparam logic [8:0]  OFS_DEC_CTRL  = 9'h151;
  localparam logic [8:0]  OFS_DEC_MODE  = 9'h152;
  localparam logic [8:0]  OFS_IRQ_STAT  = 9'h160;
  localparam logic [8:0]  OFS_IRQ_MASK  = 9'h161;
  localparam logic [8:0]  OFS_PIN_STR   = 9'h1df;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int          CTL_EN_BIT    = 0;
  localparam int          CTL_CLR_BIT   = 1;
  localparam int          CTL_POLY_BIT  = 2;
  localparam int          CTL_INV_I_BIT = 3;
  localparam int          CTL_INV_Q_BIT = 4;
  localparam int          CTL_PASS_I_BIT = 6;
  localparam int          CTL_PASS_Q_BIT = 7;
  localparam int          DC_EN_BIT     = 1;
  localparam int          SHUF_BIT      = 2;
  localparam int          MODE_W        = 2;
  localparam int          STR_W         = 4;
  localparam int          SLEW_LSB      = 0;
  localparam int          DRIVE_LSB     = 2;
  localparam int          IRQ_W         = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [4:0]  SEQ_CTRL_RST  = 5'h10;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [1:0]  MODE_RST      = 2'h0;
  localparam logic [3:0]  STR_RST       = 4'hf;
  localparam logic [1:0]  IRQ_RST       = 2'h0;

  // ---------------------------------------------------------------
  // Sequence checker
  // ---------------------------------------------------------------
  localparam int          HIST_W        = 15;
  localparam logic [3:0]  HIST_FULL     = 4'hf;
  localparam logic [7:0]  TALLY_MAX     = 8'hff;
endpackage
`default_nettype wire

// *** dtd_datapath_test.sv ***
// Behaviour
// - Each channel has a read-only pass flag: 0 after a wrong sequence value, 1 after a right one.
// - Each channel can expect normal or inverted data; imaginary resets to inverted, real to normal.
// - A polynomial select bit picks the 7-bit or 15-bit reference sequence, resetting to 7-bit.
// - The counter-clear bit clears both error counters while it is 1.
// - The real channel keeps a readable 8-bit error count that resets to zero.
// - The imaginary channel keeps its own read-only 8-bit error count that resets to zero.
// - With the constant enable set, a 16-bit constant from two bytes replaces the samples.
// - A decoder bit chooses plain thermometer coding or MSB shuffling, resetting to off.
// - A writable decode mode field selects the decoder output mode, resetting to zero.
// - A 4-bit pin strength field gives slew in its low two bits and drive in its upper two.
`default_nettype none

// -----------------------------------------------------------------
// Per-channel sequence checker
// -----------------------------------------------------------------
module dtd_seq_check #(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire logic                enable_i,
  input  wire logic                clear_i,
  input  wire logic                poly_i,
  input  wire logic                invert_i,
  input  wire logic                valid_i,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  output logic [7:0]               tally_o,
  output logic                     pass_o,
  output logic                     error_o
);
  import dtd_pkg::*;

  logic [HIST_W-1:0] hist_reg, hist_next;
  logic [3:0]        fill_reg, fill_next;
  logic [7:0]        tally_reg, tally_next;
  logic              pass_reg, pass_next;
  logic              err_reg, err_next;
  logic              rx_bit;
  logic              expect_bit;
  logic              mismatch;

  // Self-synchronising: reference predicted from received history
  always_comb begin
    rx_bit = sample_i[0] ^ invert_i;
    expect_bit = poly_i ? (hist_reg[14] ^ hist_reg[13]) : (hist_reg[6] ^ hist_reg[5]);
    mismatch = rx_bit != expect_bit;
    hist_next = hist_reg;
    fill_next = fill_reg;
    tally_next = tally_reg;
    pass_next = pass_reg;
    err_next = 1'b0;
    if (enable_i && valid_i) begin
      hist_next = {hist_reg[HIST_W-2:0], rx_bit};
      if (fill_reg != HIST_FULL) begin
        fill_next = fill_reg + 4'h1;
      end else begin
        pass_next = !mismatch;
        err_next = mismatch;
        if (mismatch && tally_reg != TALLY_MAX) begin
          tally_next = tally_reg + 8'h01;
        end
      end
    end
    if (clear_i) begin
      tally_next = BYTE_RST;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hist_reg <= '0;
      fill_reg <= 4'h0;
      tally_reg <= BYTE_RST;
      pass_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      hist_reg <= hist_next;
      fill_reg <= fill_next;
      tally_reg <= tally_next;
      pass_reg <= pass_next;
      err_reg <= err_next;
    end
  end

  assign tally_o = tally_reg;
  assign pass_o = pass_reg;
  assign error_o = err_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_POLY_TAPS: assert property (
    (enable_i && valid_i && !clear_i && fill_reg == HIST_FULL && !poly_i)
      |=> err_reg == ($past(sample_i[0] ^ invert_i) != $past(hist_reg[6] ^ hist_reg[5])))
    else $error("short sequence compare wrong");

  AST_SATURATE: assert property (
    (tally_reg == TALLY_MAX && !clear_i) |=> tally_reg == TALLY_MAX)
    else $error("error count wrapped");

  AST_HOLD_IDLE: assert property (
    (!enable_i && !clear_i) |=> ($stable(tally_reg) && $stable(pass_reg) && !err_reg))
    else $error("checker moved while disabled");
endmodule

// -----------------------------------------------------------------
// Top: register file, checkers, constant substitution
// -----------------------------------------------------------------
module dtd_datapath_test #(
  parameter int SAMPLE_W = dtd_pkg::SAMPLE_W
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  input  wire logic [dtd_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [dtd_pkg::DATA_W-1:0]  reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [dtd_pkg::DATA_W-1:0]  reg_rdata_o,
  input  wire logic [SAMPLE_W-1:0]         sample_i_i,
  input  wire logic [SAMPLE_W-1:0]         sample_q_i,
  input  wire logic                        sample_valid_i,
  output logic      [SAMPLE_W-1:0]         dac_i_o,
  output logic      [SAMPLE_W-1:0]         dac_q_o,
  output logic                             dac_valid_o,
  output logic                             shuffle_en_o,
  output logic      [dtd_pkg::MODE_W-1:0]  decode_mode_o,
  output logic      [1:0]                  pin_slew_o,
  output logic      [1:0]                  pin_drive_o,
  output logic                             irq_o
);
  import dtd_pkg::*;

  if (SAMPLE_W != 2 * DATA_W) begin : g_bad_width
    $error("SAMPLE_W must equal two register bytes");
  end

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [4:0]        ctrl_reg, ctrl_next;
  logic [7:0]        const_hi_reg, const_hi_next;
  logic [7:0]        const_lo_reg, const_lo_next;
  logic [1:0]        dig_reg, dig_next;
  logic [7:0]        dec_reg, dec_next;
  logic [MODE_W-1:0] mode_reg, mode_next;
  logic [STR_W-1:0]  str_reg, str_next;
  logic [IRQ_W-1:0]  stat_reg, stat_next;
  logic [IRQ_W-1:0]  mask_reg, mask_next;
  logic [7:0]        rdata_reg, rdata_next;
  logic              irq_reg, irq_next;
  logic [7:0]        tally_i, tally_q;
  logic              pass_i, pass_q;
  logic              err_i, err_q;

  dtd_seq_check #(.SAMPLE_W(SAMPLE_W)) u_real (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .enable_i  (ctrl_reg[CTL_EN_BIT]),
    .clear_i   (ctrl_reg[CTL_CLR_BIT]),
    .poly_i    (ctrl_reg[CTL_POLY_BIT]),
    .invert_i  (ctrl_reg[CTL_INV_I_BIT]),
    .valid_i   (sample_valid_i),
    .sample_i  (sample_i_i),
    .tally_o   (tally_i),
    .pass_o    (pass_i),
    .error_o   (err_i)
  );

  dtd_seq_check #(.SAMPLE_W(SAMPLE_W)) u_imag (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .enable_i  (ctrl_reg[CTL_EN_BIT]),
    .clear_i   (ctrl_reg[CTL_CLR_BIT]),
    .poly_i    (ctrl_reg[CTL_POLY_BIT]),
    .invert_i  (ctrl_reg[CTL_INV_Q_BIT]),
    .valid_i   (sample_valid_i),
    .sample_i  (sample_q_i),
    .tally_o   (tally_q),
    .pass_o    (pass_q),
    .error_o   (err_q)
  );

  // ---------------------------------------------------------------
  // Register writes, reads and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    const_hi_next = const_hi_reg;
    const_lo_next = const_lo_reg;
    dig_next = dig_reg;
    dec_next = dec_reg;
    mode_next = mode_reg;
    str_next = str_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    rdata_next = BYTE_RST;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_SEQ_CTRL: ctrl_next = reg_wdata_i[4:0];
        OFS_CONST_HI: const_hi_next = reg_wdata_i;
        OFS_CONST_LO: const_lo_next = reg_wdata_i;
        OFS_DIGITAL_TEST_SELECT: dig_next = reg_wdata_i[1:0];
        OFS_DEC_CTRL: dec_next = reg_wdata_i;
        OFS_DEC_MODE: mode_next = reg_wdata_i[MODE_W-1:0];
        OFS_PIN_STR:  str_next = reg_wdata_i[STR_W-1:0];
        OFS_IRQ_STAT: stat_next = stat_reg & ~reg_wdata_i[IRQ_W-1:0];
        OFS_IRQ_MASK: mask_next = reg_wdata_i[IRQ_W-1:0];
        default:      ;
      endcase
    end
    // New error beats a same-cycle clear
    stat_next = stat_next | {err_q, err_i};
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_SEQ_CTRL: rdata_next = {pass_q, pass_i, 1'b0, ctrl_reg};
        OFS_REAL_ERR: rdata_next = tally_i;
        OFS_IMAG_ERR: rdata_next = tally_q;
        OFS_CONST_HI: rdata_next = const_hi_reg;
        OFS_CONST_LO: rdata_next = const_lo_reg;
        OFS_DIGITAL_TEST_SELECT: rdata_next = {6'h00, dig_reg};
        OFS_DEC_CTRL: rdata_next = dec_reg;
        OFS_DEC_MODE: rdata_next = {6'h00, mode_reg};
        OFS_PIN_STR:  rdata_next = {4'h0, str_reg};
        OFS_IRQ_STAT: rdata_next = {6'h00, stat_reg};
        OFS_IRQ_MASK: rdata_next = {6'h00, mask_reg};
        default:      rdata_next = BYTE_RST;
      endcase
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_reg <= SEQ_CTRL_RST;
      const_hi_reg <= BYTE_RST;
      const_lo_reg <= BYTE_RST;
      dig_reg <= 2'h0;
      dec_reg <= BYTE_RST;
      mode_reg <= MODE_RST;
      str_reg <= STR_RST;
      stat_reg <= IRQ_RST;
      mask_reg <= IRQ_RST;
      rdata_reg <= BYTE_RST;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      const_hi_reg <= const_hi_next;
      const_lo_reg <= const_lo_next;
      dig_reg <= dig_next;
      dec_reg <= dec_next;
      mode_reg <= mode_next;
      str_reg <= str_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  // ---------------------------------------------------------------
  // Sample path and decoder controls
  // ---------------------------------------------------------------
  logic [SAMPLE_W-1:0] dac_i_reg, dac_i_next;
  logic [SAMPLE_W-1:0] dac_q_reg, dac_q_next;
  logic                dval_reg, dval_next;
  logic                shuf_reg, shuf_next;

  always_comb begin
    if (dig_reg[DC_EN_BIT]) begin
      dac_i_next = {const_hi_reg, const_lo_reg};
      dac_q_next = {const_hi_reg, const_lo_reg};
    end else begin
      dac_i_next = sample_i_i;
      dac_q_next = sample_q_i;
    end
    dval_next = sample_valid_i;
    shuf_next = dec_next[SHUF_BIT];
  end

  // Shuffle flop tracks the register so the pin never lags a write
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dac_i_reg <= '0;
      dac_q_reg <= '0;
      dval_reg <= 1'b0;
      shuf_reg <= 1'b0;
    end else begin
      dac_i_reg <= dac_i_next;
      dac_q_reg <= dac_q_next;
      dval_reg <= dval_next;
      shuf_reg <= shuf_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign dac_i_o = dac_i_reg;
  assign dac_q_o = dac_q_reg;
  assign dac_valid_o = dval_reg;
  assign shuffle_en_o = shuf_reg;
  assign decode_mode_o = mode_reg;
  assign pin_slew_o = str_reg[SLEW_LSB+1:SLEW_LSB];
  assign pin_drive_o = str_reg[DRIVE_LSB+1:DRIVE_LSB];
  assign irq_o = irq_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_PASS_READ: assert property (
    (reg_rd_i && reg_addr_i == OFS_SEQ_CTRL)
      |=> (reg_rdata_o[CTL_PASS_I_BIT] == $past(pass_i))
          && (reg_rdata_o[CTL_PASS_Q_BIT] == $past(pass_q)))
    else $error("pass flags misread");

  AST_INV_RESET: assert property (
    $past(rst_i) |-> (ctrl_reg[CTL_INV_Q_BIT] && !ctrl_reg[CTL_INV_I_BIT]
                      && !ctrl_reg[CTL_POLY_BIT]))
    else $error("inversion reset values wrong");

  AST_CLEAR: assert property (
    ctrl_reg[CTL_CLR_BIT] |=> (tally_i == BYTE_RST && tally_q == BYTE_RST))
    else $error("counters not cleared");

  AST_REAL_CNT: assert property (
    (reg_rd_i && reg_addr_i == OFS_REAL_ERR) |=> reg_rdata_o == $past(tally_i))
    else $error("real count misread");

  AST_IMAG_CNT: assert property (
    (reg_rd_i && reg_addr_i == OFS_IMAG_ERR) |=> reg_rdata_o == $past(tally_q))
    else $error("imag count misread");

  AST_DC_SUB: assert property (
    dig_reg[DC_EN_BIT] |=> (dac_i_o == $past({const_hi_reg, const_lo_reg}))
                           && (dac_q_o == dac_i_o))
    else $error("constant not substituted");

  AST_PASS_THRU: assert property (
    !dig_reg[DC_EN_BIT] |=> dac_i_o == $past(sample_i_i) && dac_q_o == $past(sample_q_i))
    else $error("samples not passed");

  AST_SHUFFLE: assert property (
    (reg_wr_i && reg_addr_i == OFS_DEC_CTRL) |=> shuffle_en_o == $past(reg_wdata_i[SHUF_BIT]))
    else $error("shuffle not applied");

  AST_MODE: assert property (
    (reg_wr_i && reg_addr_i == OFS_DEC_MODE)
      |=> decode_mode_o == $past(reg_wdata_i[MODE_W-1:0]))
    else $error("decode mode not applied");

  AST_STRENGTH: assert property (
    (reg_wr_i && reg_addr_i == OFS_PIN_STR)
      |=> (pin_slew_o == $past(reg_wdata_i[1:0])) && (pin_drive_o == $past(reg_wdata_i[3:2])))
    else $error("pin strength fields wrong");
endmodule
`default_nettype wire

// *** dtd_link_src.sv ***
`default_nettype none
// ---------------------------------------------------------------
// Upstream link source: one sequence bit per sample in bit 0
// ---------------------------------------------------------------
module dtd_link_src (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic        poly_i,
  input  wire logic        inv_i_i,
  input  wire logic        inv_q_i,
  input  wire logic        err_i_i,
  output logic      [15:0] sample_i_o,
  output logic      [15:0] sample_q_o,
  output logic             valid_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [14:0] lfsr;
  logic [14:0] cnt;
  logic        nb;

  assign nb = poly_i ? (lfsr[14] ^ lfsr[13]) : (lfsr[6] ^ lfsr[5]);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lfsr       <= 15'h0001;
      cnt        <= 15'h0000;
      valid_o    <= 1'b0;
      sample_i_o <= 16'h0000;
      sample_q_o <= 16'h0000;
    end else if (run_i) begin
      lfsr       <= {lfsr[13:0], nb};
      cnt        <= cnt + 15'h0001;
      valid_o    <= 1'b1;
      sample_i_o <= {cnt, nb ^ inv_i_i ^ err_i_i};
      sample_q_o <= {~cnt, nb ^ inv_q_i};
    end else begin
      // Idle lines toggle so stale data never looks valid
      valid_o    <= 1'b0;
      sample_i_o <= ~sample_i_o;
      sample_q_o <= ~sample_q_o;
    end
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import dtd_pkg::*;
  logic                clk_sys_i, rst_i, reg_wr_i, reg_rd_i, sample_valid_i;
  logic [ADDR_W-1:0]   reg_addr_i;
  logic [DATA_W-1:0]   reg_wdata_i, reg_rdata_o, r, hi, lo;
  logic [SAMPLE_W-1:0] sample_i_i, sample_q_i, dac_i_o, dac_q_o, prev_i, prev_q;
  logic                dac_valid_o, shuffle_en_o, irq_o, rd_seen;
  logic [MODE_W-1:0]   decode_mode_o;
  logic [1:0]          pin_slew_o, pin_drive_o;
  logic                run, poly, inv_i, inv_q, err_i;
  logic [7:0]          exp_q[$];
  logic [8:0]          adr_q[$];
  logic [8:0]          ra[12] = '{9'h14b, 9'h14c, 9'h14d, 9'h14e, 9'h14f, 9'h150,
                                  9'h151, 9'h152, 9'h1df, 9'h160, 9'h161, 9'h100};
  logic [7:0]          rv[12] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                  8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00};
  int                  fail_count, check_count, seed;

  dtd_datapath_test #(.SAMPLE_W(16)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sample_i_i(sample_i_i), .sample_q_i(sample_q_i),
    .sample_valid_i(sample_valid_i), .dac_i_o(dac_i_o), .dac_q_o(dac_q_o),
    .dac_valid_o(dac_valid_o), .shuffle_en_o(shuffle_en_o),
    .decode_mode_o(decode_mode_o), .pin_slew_o(pin_slew_o),
    .pin_drive_o(pin_drive_o), .irq_o(irq_o));

  dtd_link_src src_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run), .poly_i(poly),
    .inv_i_i(inv_i), .inv_q_i(inv_q), .err_i_i(err_i),
    .sample_i_o(sample_i_i), .sample_q_o(sample_q_i), .valid_o(sample_valid_i));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic at_mid(input int n);
    cyc(n);
    @(negedge clk_sys_i);
  endtask

  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    cyc(1);
    reg_wr_i    <= 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    adr_q.push_back(a);
    exp_q.push_back(e);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    cyc(1);
    reg_rd_i   <= 1'b0;
    cyc(1);
  endtask

  task automatic reset_all(input logic p, input logic qi, input logic qq);
    rst_i <= 1'b1;
    poly  <= p;
    inv_i <= qi;
    inv_q <= qq;
    cyc(2);
    rst_i <= 1'b0;
    cyc(2);
  endtask

  // ---------------------------------------------------------------
  // Clock, monitor, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    rd_seen <= reg_rd_i;
    prev_i  <= sample_i_i;
    prev_q  <= sample_q_i;
  end

  always @(negedge clk_sys_i) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("read data without note", 16'h0001, 16'h0000);
      end else begin
        check($sformatf("reg %h", adr_q.pop_front()), {8'h00, reg_rdata_o},
              {8'h00, exp_q.pop_front()});
      end
    end
  end

  initial begin
    cyc(20000);
    fail_count++;
    $display("Error watchdog expected done seen hang");
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 19;
    rst_i = 1'b1;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    run = 1'b1;
    poly = 1'b0;
    inv_i = 1'b0;
    inv_q = 1'b0;
    err_i = 1'b0;
    cyc(2);
    rst_i <= 1'b0;
    cyc(2);
    at_mid(0);
    check("slew", {14'h0, pin_slew_o}, 16'h3);
    check("drive", {14'h0, pin_drive_o}, 16'h3);
    cyc(1);
    // Wrong-inversion imag data flows while the checker is off
    wr(9'h100, 8'hff);
    wr(OFS_REAL_ERR, 8'h5a);
    cyc(60);
    for (int k = 0; k < 12; k++) begin
      rd(ra[k], rv[k]);
    end
    $display("test reset values done");
    for (int k = 0; k < 2; k++) begin
      r = 8'($random(seed));
      r = (k == 0) ? r : ~r;
      wr(OFS_DEC_CTRL, r);
      rd(OFS_DEC_CTRL, r);
      at_mid(0);
      check("shuffle", {15'h0, shuffle_en_o}, {15'h0, r[2]});
      cyc(1);
    end
    for (int m = 0; m < 4; m++) begin
      wr(OFS_DEC_MODE, {6'h3f, m[1:0]});
      rd(OFS_DEC_MODE, {6'h00, m[1:0]});
      at_mid(0);
      check("decode mode", {14'h0, decode_mode_o}, {14'h0, m[1:0]});
      cyc(1);
    end
    r = 8'($random(seed));
    wr(OFS_PIN_STR, r);
    rd(OFS_PIN_STR, {4'h0, r[3:0]});
    at_mid(0);
    check("slew", {14'h0, pin_slew_o}, {14'h0, r[1:0]});
    check("drive", {14'h0, pin_drive_o}, {14'h0, r[3:2]});
    cyc(1);
    $display("test decoder and pins done");
    hi = 8'($random(seed));
    lo = 8'($random(seed));
    wr(OFS_CONST_HI, hi);
    wr(OFS_CONST_LO, lo);
    wr(OFS_DIGITAL_TEST_SELECT, 8'hff);
    rd(OFS_DIGITAL_TEST_SELECT, 8'h03);
    rd(OFS_CONST_HI, hi);
    rd(OFS_CONST_LO, lo);
    at_mid(0);
    check("dac valid", {15'h0, dac_valid_o}, 16'h1);
    check("dac i", dac_i_o, {hi, lo});
    check("dac q", dac_q_o, {hi, lo});
    cyc(1);
    wr(OFS_DIGITAL_TEST_SELECT, 8'h00);
    at_mid(1);
    check("dac i", dac_i_o, prev_i);
    check("dac q", dac_q_o, prev_q);
    cyc(1);
    $display("test constant level done");
    // Imag channel expects inverted data but gets normal: every compare fails
    wr(OFS_SEQ_CTRL, 8'h11);
    cyc(300);
    rd(OFS_REAL_ERR, 8'h00);
    rd(OFS_IMAG_ERR, 8'hff);
    rd(OFS_SEQ_CTRL, 8'h51);
    rd(OFS_IRQ_STAT, 8'h02);
    at_mid(0);
    check("irq masked", {15'h0, irq_o}, 16'h0);
    cyc(1);
    wr(OFS_IRQ_MASK, 8'h02);
    at_mid(1);
    check("irq unmasked", {15'h0, irq_o}, 16'h1);
    cyc(1);
    wr(OFS_SEQ_CTRL, 8'h13);
    cyc(20);
    rd(OFS_REAL_ERR, 8'h00);
    rd(OFS_IMAG_ERR, 8'h00);
    rd(OFS_SEQ_CTRL, 8'h53);
    $display("test saturation and clear done");
    // One flipped bit hits the compare three times: direct and at both taps
    reset_all(1'b1, 1'b1, 1'b1);
    wr(OFS_SEQ_CTRL, 8'h1d);
    cyc(40);
    // Idle gap: toggling lines with valid low must not count
    run <= 1'b0;
    at_mid(2);
    check("dac valid", {15'h0, dac_valid_o}, 16'h0);
    cyc(1);
    run   <= 1'b1;
    err_i <= 1'b1;
    cyc(1);
    err_i <= 1'b0;
    cyc(40);
    rd(OFS_REAL_ERR, 8'h03);
    rd(OFS_IMAG_ERR, 8'h00);
    rd(OFS_SEQ_CTRL, 8'hdd);
    rd(OFS_IRQ_STAT, 8'h01);
    wr(OFS_IRQ_MASK, 8'h01);
    at_mid(1);
    check("irq raised", {15'h0, irq_o}, 16'h1);
    cyc(1);
    wr(OFS_IRQ_STAT, 8'h01);
    rd(OFS_IRQ_STAT, 8'h00);
    at_mid(1);
    check("irq cleared", {15'h0, irq_o}, 16'h0);
    $display("test long polynomial done");
    cyc(2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
